// ==== src/tcc_pkg.sv ====
// Constants for the elapsed-time capture counter.
// Assumes one 200 MHz system clock; the counter tick is an enable pulse.
package tcc_pkg;
  // ****************************************
  // Widths and codes
  // ****************************************
  localparam int COUNT_W = 40;
  localparam int BYTE_W = 8;
  localparam int NUM_BYTES = 5;
  localparam logic [7:0] PIN_CAPTURE_FUNCTION = 8'h27;
  localparam logic VCO_SEL_THIRD = 1'h0;
  localparam logic VCO_SEL_SECOND = 1'h1;
  localparam logic TRIG_SEL_CHIP_SELECT = 1'h0;
  localparam logic TRIG_SEL_PIN = 1'h1;
  // Byte index of the capture field, MSB first
  localparam logic [2:0] BYTE_IDX_MSB = 3'h0;
  localparam logic [2:0] BYTE_IDX_LSB = 3'h4;
  // ****************************************
  // Divider ratios of the oscillator clocks, and counter constants
  // ****************************************
  localparam logic [4:0] DIV_SECOND = 5'h14;
  localparam logic [4:0] DIV_THIRD = 5'h08;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 40'h00_0000_0000;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 40'h00_0000_0001;
endpackage

// ==== src/tick_divider.sv ====
// Divides an oscillator-cycle enable into a counter tick enable.
// Assumes osc_tick comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module tick_divider (
  input wire logic clock, // System clock
  input wire logic reset, // Async reset, active high
  input wire logic osc_tick, // One oscillator cycle
  input wire logic [4:0] ratio, // Division ratio
  output logic tick // Counter enable pulse
);
  logic [4:0] phase;
  // Wrap at ratio-1; a ratio change restarts cleanly at the wrap
  wire last = (phase >= ratio - 5'h01);
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      phase <= 5'h00;
    end else if (osc_tick) begin
      phase <= last ? 5'h00 : phase + 5'h01;
    end
  end
  assign tick = osc_tick & last;
endmodule
`default_nettype wire

// ==== src/time_capture_counter.sv ====
// Elapsed-time counter with snapshot capture into a five-byte field.
// Assumes the oscillator ticks and host byte reads come from same-clock
// logic; the trigger pin and chip select arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none
module time_capture_counter (
  input wire logic clock, // System clock, 200 MHz
  input wire logic reset, // Async reset, active high
  input wire logic second_osc_tick, // Second synthesizer VCO cycle
  input wire logic third_osc_tick, // Third synthesizer VCO cycle
  input wire logic counter_vco_source_sel, // 0 third, 1 second
  input wire logic capture_trigger_sel, // 1 pin, 0 chip select
  input wire logic elapsed_counter_enable, // Counter run enable
  input wire logic elapsed_counter_clear, // Extra clear, keep 0
  input wire logic [7:0] pin_function_code, // Trigger pin function
  input wire logic pin_polarity_invert, // 1 selects falling edge
  input wire logic general_pin_one, // Trigger pin, async
  input wire logic serial_chip_select_n, // Serial select, async
  input wire logic read_strobe, // Host byte read pulse
  input wire logic [2:0] read_index, // Byte index, 0 is MSB
  output logic [7:0] read_data, // Selected capture byte
  output logic [39:0] captured_count_value, // Whole capture field
  output logic [39:0] running_count, // Live counter
  output logic capture_armed // Capture may be taken
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [2:0] pin_sync;
  logic [2:0] cs_sync;
  logic pin_held;
  logic cs_held;
  // Three stages; a change counts once stages two and three agree,
  // so a one-cycle glitch at the last stage never makes an edge
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pin_sync <= 3'h0;
      cs_sync <= 3'h7;
    end else begin
      pin_sync <= {pin_sync[1:0], general_pin_one};
      cs_sync <= {cs_sync[1:0], serial_chip_select_n};
    end
  end
  wire pin_agree = (pin_sync[1] == pin_sync[2]);
  wire cs_agree = (cs_sync[1] == cs_sync[2]);
  // Last accepted level, reset to each pin's idle level
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pin_held <= 1'h0;
      cs_held <= 1'h1;
    end else begin
      if (pin_agree) begin
        pin_held <= pin_sync[2];
      end
      if (cs_agree) begin
        cs_held <= cs_sync[2];
      end
    end
  end
  wire pin_level = pin_sync[2] ^ pin_polarity_invert;
  wire pin_prev = pin_held ^ pin_polarity_invert;
  wire pin_edge = pin_agree & pin_level & ~pin_prev;
  wire cs_fall = cs_agree & ~cs_sync[2] & cs_held;

  // ****************************************
  // Counter clock selection and division
  // ****************************************
  wire use_second =
    (counter_vco_source_sel == tcc_pkg::VCO_SEL_SECOND);
  // Oscillator source mux; ratio tracks the source
  wire osc_tick = use_second ? second_osc_tick : third_osc_tick;
  wire [4:0] div_ratio = use_second ? tcc_pkg::DIV_SECOND
                                    : tcc_pkg::DIV_THIRD;
  logic count_tick;
  tick_divider divider (
    .clock(clock),
    .reset(reset),
    .osc_tick(osc_tick),
    .ratio(div_ratio),
    .tick(count_tick)
  );

  // ****************************************
  // Running counter
  // ****************************************
  wire run = elapsed_counter_enable & ~elapsed_counter_clear;
  // Held at zero while disabled, so enabling starts from zero
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      running_count <= tcc_pkg::COUNT_ZERO;
    end else if (!run) begin
      running_count <= tcc_pkg::COUNT_ZERO;
    end else if (count_tick) begin
      running_count <= running_count + tcc_pkg::COUNT_ONE;
    end
  end

  // ****************************************
  // Capture and re-arm
  // ****************************************
  wire pin_mode = (capture_trigger_sel == tcc_pkg::TRIG_SEL_PIN);
  wire pin_is_trigger = (pin_function_code == tcc_pkg::PIN_CAPTURE_FUNCTION);
  wire trig_event = pin_mode ? (pin_edge & pin_is_trigger)
                             : cs_fall;
  wire read_msb = read_strobe & (read_index == tcc_pkg::BYTE_IDX_MSB);
  wire read_lsb = read_strobe & (read_index == tcc_pkg::BYTE_IDX_LSB);
  wire take = run & capture_armed & trig_event;
  // Chip select locks on MSB read, pin locks on its own capture.
  // An LSB read re-arms; a lock in the same cycle wins so no
  // capture is lost between a read and the next edge.
  wire lock = pin_mode ? take : read_msb;
  logic next_armed;
  always_comb begin
    next_armed = capture_armed;
    if (read_lsb) begin
      next_armed = 1'b1;
    end
    if (lock) begin
      next_armed = 1'b0;
    end
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      capture_armed <= 1'b1;
      captured_count_value <= tcc_pkg::COUNT_ZERO;
    end else begin
      capture_armed <= next_armed;
      if (take) begin
        captured_count_value <= running_count;
      end
    end
  end

  // ****************************************
  // Byte read port
  // ****************************************
  // One lane per field byte, MSB first; indices past the field read zero
  logic [7:0] field_byte [tcc_pkg::NUM_BYTES];
  for (genvar b = 0; b < tcc_pkg::NUM_BYTES; b++) begin : g_lane
    assign field_byte[b] = captured_count_value[
      tcc_pkg::COUNT_W - 1 - tcc_pkg::BYTE_W * b -: tcc_pkg::BYTE_W];
  end
  wire index_ok = (read_index <= tcc_pkg::BYTE_IDX_LSB);
  wire [7:0] byte_sel = index_ok ? field_byte[read_index] : 8'h00;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      read_data <= 8'h00;
    end else if (read_strobe) begin
      read_data <= byte_sel;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  hold_zero_a: assert property (
    @(posedge clock) disable iff (reset)
    !run |=> running_count == tcc_pkg::COUNT_ZERO)
    else $error("count not held at zero");
  count_step_a: assert property (
    @(posedge clock) disable iff (reset)
    run && $past(run) && !count_tick |=> $stable(running_count))
    else $error("count moved without tick");
  capture_copy_a: assert property (
    @(posedge clock) disable iff (reset)
    take |=> captured_count_value == $past(running_count))
    else $error("capture value wrong");
  pin_lock_a: assert property (
    @(posedge clock) disable iff (reset)
    pin_mode && take && !read_lsb |=> !capture_armed)
    else $error("pin capture did not lock");
  msb_lock_a: assert property (
    @(posedge clock) disable iff (reset)
    !pin_mode && read_msb |=> !capture_armed)
    else $error("msb read did not lock");
  lsb_rearm_a: assert property (
    @(posedge clock) disable iff (reset)
    read_lsb && !lock |=> capture_armed)
    else $error("lsb read did not re-arm");
  locked_hold_a: assert property (
    @(posedge clock) disable iff (reset)
    !capture_armed |=> $stable(captured_count_value))
    else $error("capture changed while locked");
  idle_nocap_a: assert property (
    @(posedge clock) disable iff (reset)
    !run |=> $stable(captured_count_value))
    else $error("capture while disabled");
  // Chip-select captures leave the field armed until the MSB is read
  cs_keep_a: assert property (
    @(posedge clock) disable iff (reset)
    !pin_mode && take && !read_msb |=> capture_armed)
    else $error("chip select capture disarmed");
  lock_wins_a: assert property (
    @(posedge clock) disable iff (reset)
    lock && read_lsb |=> !capture_armed)
    else $error("re-arm overrode a lock");
  // Each accepted input change yields one edge only
  cs_once_a: assert property (
    @(posedge clock) disable iff (reset)
    cs_fall |=> !cs_fall)
    else $error("chip select edge seen twice");
  pin_once_a: assert property (
    @(posedge clock) disable iff (reset)
    pin_edge |=> !pin_edge)
    else $error("pin edge seen twice");
  msb_byte_a: assert property (
    @(posedge clock) disable iff (reset)
    read_msb |=> read_data == $past(
      captured_count_value[tcc_pkg::COUNT_W-1 -: tcc_pkg::BYTE_W]))
    else $error("msb byte wrong");
  lsb_byte_a: assert property (
    @(posedge clock) disable iff (reset)
    read_lsb |=> read_data ==
      $past(captured_count_value[tcc_pkg::BYTE_W-1:0]))
    else $error("lsb byte wrong");
  cap_pin_c: cover property (@(posedge clock) pin_mode && take);
  cap_cs_c: cover property (@(posedge clock) !pin_mode && take);
  rearm_c: cover property (@(posedge clock) !capture_armed ##1 read_lsb);
  cap_fall_c: cover property (@(posedge clock)
    pin_mode && pin_polarity_invert && take);
  cs_blocked_c: cover property (@(posedge clock)
    !pin_mode && cs_fall && !capture_armed);
endmodule
`default_nettype wire

// ==== tb/trigger_source.sv ====
// Trigger pulse source in front of the capture pin.
// Assumes fire is a one-cycle request on the bench clock.
`timescale 1ns/1ps
`default_nettype none
module trigger_source (
  input wire logic clock, // Bench clock
  input wire logic fire, // Start one pulse
  output logic pin // Trigger pin level
);
  logic [2:0] width = 3'h0;
  // Four cycles high is 20 ns, safely above the minimum width
  always @(posedge clock) begin
    if (fire) width <= 3'h4;
    else if (width != 3'h0) width <= width - 3'h1;
  end
  assign pin = (width != 3'h0);
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the elapsed-time capture counter.
// Assumes the design files and trigger_source are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock, reset, vsel, tsel, enable, pol, cs_n, strobe, fire, clr;
  logic [7:0] func;
  logic [2:0] idx;
  logic [39:0] snap, mark, prior;
  logic osc3 = 1'h0;
  wire logic pin, armed;
  wire logic [7:0] rdata;
  wire logic [39:0] cap, run;
  int errors, comparisons;
  time_capture_counter dut (.clock(clock), .reset(reset),
    .second_osc_tick(1'b1), .third_osc_tick(osc3),
    .counter_vco_source_sel(vsel), .capture_trigger_sel(tsel),
    .elapsed_counter_enable(enable), .elapsed_counter_clear(clr),
    .pin_function_code(func), .pin_polarity_invert(pol),
    .general_pin_one(pin), .serial_chip_select_n(cs_n),
    .read_strobe(strobe), .read_index(idx), .read_data(rdata),
    .captured_count_value(cap), .running_count(run),
    .capture_armed(armed));
  trigger_source source (.clock(clock), .fire(fire), .pin(pin));
  always #2.5 clock = ~clock;
  // Third oscillator at half rate, so a wrong source pick shows
  always @(negedge clock) osc3 <= ~osc3;
  // Compare and tally
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Fresh capture: new value, equal to the count at the trigger or
  // one tick on, since the sync path is shorter than a tick
  function automatic logic fresh();
    return cap != prior && (cap == mark || cap == mark + 40'h1);
  endfunction
  task automatic wait_n(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic rd(input int i);
    @(negedge clock);
    strobe = 1'b1;
    idx = 3'(i);
    @(negedge clock);
    strobe = 1'b0;
  endtask
  // Long gap keeps successive captures at least one tick apart
  task automatic cs_fall;
    @(negedge clock);
    prior = cap;
    mark = run;
    cs_n = 1'b0;
    wait_n(8);
    cs_n = 1'b1;
    wait_n(24);
  endtask
  task automatic pulse;
    @(negedge clock);
    prior = cap;
    mark = run;
    fire = 1'b1;
    @(negedge clock);
    fire = 1'b0;
    wait_n(10);
  endtask
  task automatic summarize;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Whole run is about 1100 cycles; allow about nine times that
  initial begin
    #50000;
    errors++;
    summarize();
  end
  initial begin
    {clock, vsel, tsel, enable, pol, strobe, fire, clr} = 8'h00;
    {reset, cs_n, func, idx, errors, comparisons} = 0;
    reset = 1'b1;
    cs_n = 1'b1;
    wait_n(16);
    reset = 1'b0;
    check(40'(armed), 40'h1);
    wait_n(40);
    check(run, 40'h0);
    $display("test reset done");
    enable = 1'b1;
    wait_n(4);
    snap = run;
    wait_n(80);
    // Half-rate third oscillator over eight: one tick per 16 cycles
    check(run - snap, 40'h5);
    vsel = 1'b1;
    wait_n(40);
    snap = run;
    wait_n(200);
    check(run - snap, 40'hA);
    clr = 1'b1;
    wait_n(4);
    check(run, 40'h0);
    clr = 1'b0;
    wait_n(40);
    $display("test rate done");
    cs_fall();
    check(40'(fresh()), 40'h1);
    cs_fall();
    check(40'(fresh()), 40'h1);
    snap = cap;
    for (int i = 0; i < 5; i++) begin
      rd(i);
      check(40'(rdata), 40'(snap[39-8*i -: 8]));
      if (i == 0) begin
        check(40'(armed), 40'h0);
        cs_fall();
        check(cap, snap);
      end
    end
    cs_fall();
    check(40'(fresh()), 40'h1);
    $display("test chip select done");
    tsel = 1'b1;
    func = 8'h27;
    snap = cap;
    cs_fall();
    check(cap, snap);
    pulse();
    check(40'(fresh()), 40'h1);
    snap = cap;
    wait_n(40);
    pulse();
    check(cap, snap);
    pol = 1'b1;
    rd(4);
    check(40'(armed), 40'h1);
    wait_n(200);
    pulse();
    check(40'(fresh()), 40'h1);
    rd(4);
    wait_n(200);
    func = 8'h26;
    snap = cap;
    pulse();
    check(cap, snap);
    func = 8'h27;
    enable = 1'b0;
    wait_n(4);
    pulse();
    check(run, 40'h0);
    check(cap, snap);
    $display("test pin done");
    summarize();
  end
endmodule
`default_nettype wire
